/* hw/sct_axil_slave.sv */
/*
  axi4-lite slave front end: takes one write and one read at a time and
  hands word accesses to the register file.
  assumes the register file decodes and answers in the same cycle.
*/
`timescale 1ns/100ps
`include "sct_cfg.svh"

module sct_axil_slave
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register file side
  output logic             reg_wr,
  output logic [15:0]      reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_wr_ok,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rd_ok
);

  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire ar_take = arvalid && arready;
  // both halves held and no answer out yet
  assign reg_wr = !awready && !wready && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `SCT_RESP_OKAY;
      reg_waddr <= 16'h0000;
      reg_wdata <= 32'h0000_0000;
      reg_wstrb <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        awready   <= 1'b0;
        reg_waddr <= awaddr;
      end
      if (w_take)
      begin
        wready    <= 1'b0;
        reg_wdata <= wdata;
        reg_wstrb <= wstrb;
      end
      if (reg_wr)
      begin
        bvalid <= 1'b1;
        bresp  <= reg_wr_ok ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SCT_RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= reg_rdata;
      rresp   <= reg_rd_ok ? `SCT_RESP_OKAY : `SCT_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : sct_axil_slave

/* hw/sct_cfg.svh */
/*
  constants of the step-count and interrupt trigger: word indexes, field
  positions, type codes and reset values.
  assumes it is included by bare name before any use of the macros.
*/
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

// Summary of operation
// - config word shows the step trigger when its type field reads 3.
// - step trigger matches on retirement fetched in an enabled mode, returns too.
// - step trigger matches on any trap taken from an enabled mode.
// - retirement plus trap of one instruction counts as a single match.
// - match with count above one decrements count, pending untouched.
// - match with count one sets pending, clears count unless wired to one.
// - config write by the matching instruction may skip pending; written count stays.
// - zero count stays zero until software writes it.
// - pending fires before next instruction in enabled mode, clearing pending.
// - wired-to-one count clears all five mode enables on firing.
// - step trigger firing with action zero writes zero trap value.
// - implemented qualifier conditions must also hold for a match.
// - count is 14 bits at 23..10, resets to one, legal values.
// - hit set by hardware on fire or match, software writes it; absent reads zero.
// - enables of absent modes are hard-wired to zero.
// - config word shows the interrupt trigger when its type field reads 4.
// - interrupt trap fires when its code bit is set in the match word.
// - nmi enable lets non-maskable interrupts fire in enabled modes.
// - each interrupt mode enable qualifies interrupts taken from that mode.
// - interrupt trigger fires before handler entry; action zero zeroes trap value.
// - unsupported interrupt enable bits read back zero.
// - only interrupt codes 0..31 are selectable in the 32-bit match word.

// word indexes; byte address is four times the index
`define SCT_IDX_SELECT 12'h7a0
`define SCT_IDX_CONFIG 12'h7a1
`define SCT_IDX_MATCH  12'h7a2
`define SCT_IDX_STATUS 12'h7a4

// fields of the configuration word
`define SCT_TYPE_HI    31
`define SCT_TYPE_LO    28
`define SCT_TYPE_STEP  4'h3
`define SCT_TYPE_IRQ   4'h4
`define SCT_ST_VS      26
`define SCT_ST_VU      25
`define SCT_ST_HIT     24
`define SCT_CNT_HI     23
`define SCT_CNT_LO     10
`define SCT_F_M        9
`define SCT_ST_PEND    8
`define SCT_F_S        7
`define SCT_F_U        6
`define SCT_ACT_HI     5
`define SCT_ACT_LO     0
`define SCT_IR_HIT     26
`define SCT_IR_VS      12
`define SCT_IR_VU      11
`define SCT_IR_NMI     10

// reset values and bus answers
`define SCT_CNT_RESET  14'h0001
`define SCT_ACT_RESET  6'h00
`define SCT_RESP_OKAY  2'h0
`define SCT_RESP_SLVERR 2'h2

`endif

/* hw/sct_pkg.sv */
/*
  types of the step-count and interrupt trigger.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sct_pkg;

  // privilege mode of an event, one bit per mode
  typedef enum logic [4:0]
  {
    SCT_MODE_M  = 5'h01,
    SCT_MODE_S  = 5'h02,
    SCT_MODE_U  = 5'h04,
    SCT_MODE_VS = 5'h08,
    SCT_MODE_VU = 5'h10
  } sct_mode_type;

endpackage : sct_pkg

/* hw/sct_top.sv */
/*
  step-count and interrupt trigger: two trigger slots behind one
  configuration word, selected by a select register, reached over axi4-lite.
  assumes the hart reports retirement, traps, handler entry and the next
  instruction about to execute as one-cycle strobes on aclk.
*/
`timescale 1ns/100ps
`include "sct_cfg.svh"

module sct_top
#(
  parameter bit          HAS_S          = 1'b1,
  parameter bit          HAS_U          = 1'b1,
  parameter bit          HAS_VIRT       = 1'b0,
  parameter bit          HIT_IMPL       = 1'b1,
  parameter bit          COUNT_ONE_ONLY = 1'b0,
  parameter logic [31:0] IRQ_IMPL       = 32'hffff_ffff
)
(
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write
  input  wire logic [15:0]               awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [15:0]               araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // hart retirement and traps
  input  wire logic                      retire_valid,
  input  wire sct_pkg::sct_mode_type     retire_mode,
  input  wire logic                      retire_cfg_write,
  input  wire logic                      trap_valid,
  input  wire sct_pkg::sct_mode_type     trap_from_mode,
  input  wire logic                      trap_is_irq,
  input  wire logic                      trap_is_nmi,
  input  wire logic [4:0]                trap_irq_code,
  // hart execution points
  input  wire logic                      exec_valid,
  input  wire sct_pkg::sct_mode_type     exec_mode,
  input  wire logic                      handler_entry,
  // firing toward the debug logic
  output logic                           fire_q,
  output logic                           fire_irq_q,
  output logic [5:0]                     fire_action_q,
  output logic                           fire_tval_zero_q
);

  import sct_pkg::*;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------

  logic        reg_wr;
  logic [15:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_wstrb;
  logic        reg_wr_ok;
  logic [31:0] reg_rdata;
  logic        reg_rd_ok;

  sct_axil_slave u_bus
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .reg_wr_ok (reg_wr_ok),
    .reg_rdata (reg_rdata),
    .reg_rd_ok (reg_rd_ok)
  );

  // ----------------------------------------------------------------
  // trigger state
  // ----------------------------------------------------------------

  logic        sel_q;
  logic [4:0]  st_en_q;
  logic        st_hit_q;
  logic [13:0] st_cnt_q;
  logic        st_pend_q;
  logic [5:0]  st_act_q;
  logic [4:0]  ir_en_q;
  logic        ir_nmi_q;
  logic        ir_hit_q;
  logic [5:0]  ir_act_q;
  logic [31:0] ir_mask_q;
  logic        ir_armed_q;
  logic        ir_fire;

  // enables of modes the hart lacks stay zero
  wire [4:0] en_legal = {HAS_VIRT, HAS_VIRT, HAS_U, HAS_S, 1'b1};

  // ----------------------------------------------------------------
  // register view
  // ----------------------------------------------------------------

  wire [31:0] st_word = {`SCT_TYPE_STEP, 1'b0, st_en_q[3], st_en_q[4], st_hit_q,
                         st_cnt_q, st_en_q[0], st_pend_q, st_en_q[1], st_en_q[2],
                         st_act_q};
  wire [31:0] ir_word = {`SCT_TYPE_IRQ, 1'b0, ir_hit_q, 13'h0000,
                         ir_en_q[3], ir_en_q[4], ir_nmi_q, ir_en_q[0], 1'b0,
                         ir_en_q[1], ir_en_q[2], ir_act_q};
  wire [31:0] cfg_word   = sel_q ? ir_word : st_word;
  wire [31:0] match_word = sel_q ? ir_mask_q : 32'h0000_0000;
  wire [31:0] stat_word  = {28'h0000000, ir_armed_q, st_cnt_q == 14'h0000,
                            st_pend_q, sel_q};
  wire [31:0] sel_word   = {31'h00000000, sel_q};

  function automatic logic [31:0] reg_view
  (
    input logic [15:0] addr,
    input logic [31:0] sel_w,
    input logic [31:0] cfg_w,
    input logic [31:0] match_w,
    input logic [31:0] stat_w
  );
    logic [11:0] idx;
    idx      = addr[13:2];
    reg_view = 32'h0000_0000;
    if (addr[15:14] == 2'h0)
    begin
      case (idx)
        `SCT_IDX_SELECT: reg_view = sel_w;
        `SCT_IDX_CONFIG: reg_view = cfg_w;
        `SCT_IDX_MATCH:  reg_view = match_w;
        `SCT_IDX_STATUS: reg_view = stat_w;
        default:         reg_view = 32'h0000_0000;
      endcase
    end
  endfunction : reg_view

  function automatic logic is_mapped
  (
    input logic [15:0] addr
  );
    is_mapped = (addr[15:14] == 2'h0) &&
                (addr[13:2] == `SCT_IDX_SELECT || addr[13:2] == `SCT_IDX_CONFIG ||
                 addr[13:2] == `SCT_IDX_MATCH  || addr[13:2] == `SCT_IDX_STATUS);
  endfunction : is_mapped

  assign reg_rdata = reg_view(araddr, sel_word, cfg_word, match_word, stat_word);
  assign reg_rd_ok = is_mapped(araddr);
  assign reg_wr_ok = is_mapped(reg_waddr);

  // ----------------------------------------------------------------
  // write decode with byte lanes
  // ----------------------------------------------------------------

  logic [31:0] lane_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{reg_wstrb[gi]}};
    end
  endgenerate

  wire [31:0] old_word = reg_view(reg_waddr, sel_word, cfg_word, match_word, stat_word);
  wire [31:0] wm       = (old_word & ~lane_mask) | (reg_wdata & lane_mask);
  wire [11:0] widx     = reg_waddr[13:2];
  wire        wr_ok    = reg_wr && reg_wr_ok;
  wire        wr_sel   = wr_ok && widx == `SCT_IDX_SELECT;
  wire        wr_st    = wr_ok && widx == `SCT_IDX_CONFIG && !sel_q;
  wire        wr_ir    = wr_ok && widx == `SCT_IDX_CONFIG && sel_q;
  wire        wr_mask  = wr_ok && widx == `SCT_IDX_MATCH && sel_q;

  wire [4:0]  st_en_w  = {wm[`SCT_ST_VU], wm[`SCT_ST_VS], wm[`SCT_F_U], wm[`SCT_F_S],
                          wm[`SCT_F_M]} & en_legal;
  wire [4:0]  ir_en_w  = {wm[`SCT_IR_VU], wm[`SCT_IR_VS], wm[`SCT_F_U], wm[`SCT_F_S],
                          wm[`SCT_F_M]} & en_legal;
  // any 14-bit value is legal unless the count is wired to one
  wire [13:0] cnt_w    = COUNT_ONE_ONLY ? `SCT_CNT_RESET
                                        : wm[`SCT_CNT_HI:`SCT_CNT_LO];

  // ----------------------------------------------------------------
  // instruction-count trigger
  // ----------------------------------------------------------------

  // no qualifier registers exist, so only mode enables qualify a match
  wire st_ret   = retire_valid && |(retire_mode & st_en_q);
  wire st_trap  = trap_valid && |(trap_from_mode & st_en_q);
  wire st_match = st_ret || st_trap;
  wire cnt_one  = st_cnt_q == 14'h0001;
  wire cnt_big  = st_cnt_q > 14'h0001;

  // an interrupt-trigger firing in the same cycle goes first; pending stays
  // set and fires at the next eligible instruction
  wire st_fire  = st_pend_q && exec_valid && |(exec_mode & st_en_q) && !ir_fire;
  wire pend_set = st_match && cnt_one && !retire_cfg_write && !wr_st;

  logic [13:0] st_cnt_d;
  logic        st_pend_d;
  logic [4:0]  st_en_d;
  logic        st_hit_d;

  always_comb
  begin
    st_cnt_d = st_cnt_q;
    if (wr_st)
      st_cnt_d = cnt_w;
    else if (st_match && cnt_big && !retire_cfg_write)
      st_cnt_d = st_cnt_q - 14'h0001;
    else if (st_match && cnt_one && !COUNT_ONE_ONLY && !retire_cfg_write)
      st_cnt_d = 14'h0000;
  end

  always_comb
  begin
    st_pend_d = st_pend_q;
    if (wr_st)
      st_pend_d = wm[`SCT_ST_PEND];
    else if (st_fire)
      st_pend_d = 1'b0;
    if (pend_set)
      st_pend_d = 1'b1;
  end

  always_comb
  begin
    st_en_d = st_en_q;
    if (wr_st)
      st_en_d = st_en_w;
    else if (st_fire && COUNT_ONE_ONLY)
      st_en_d = 5'h00;
  end

  // a hardware set wins over a software clear in the same cycle
  assign st_hit_d = HIT_IMPL && ((wr_st ? wm[`SCT_ST_HIT] : st_hit_q) || st_fire);

  // ----------------------------------------------------------------
  // interrupt trigger
  // ----------------------------------------------------------------

  wire ir_code_on = ir_mask_q[trap_irq_code];
  wire ir_src_on  = trap_is_nmi ? ir_nmi_q : ir_code_on;
  wire ir_match   = trap_valid && trap_is_irq && |(trap_from_mode & ir_en_q)
                    && ir_src_on;
  assign ir_fire  = handler_entry && (ir_armed_q || ir_match);

  wire ir_hit_d   = HIT_IMPL && ((wr_ir ? wm[`SCT_IR_HIT] : ir_hit_q) || ir_match);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q     <= 1'b0;
      st_en_q   <= 5'h00;
      st_hit_q  <= 1'b0;
      st_cnt_q  <= `SCT_CNT_RESET;
      st_pend_q <= 1'b0;
      st_act_q  <= `SCT_ACT_RESET;
    end
    else
    begin
      if (wr_sel)
        sel_q <= wm[0];
      st_en_q   <= st_en_d;
      st_hit_q  <= st_hit_d;
      st_cnt_q  <= st_cnt_d;
      st_pend_q <= st_pend_d;
      if (wr_st)
        st_act_q <= wm[`SCT_ACT_HI:`SCT_ACT_LO];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ir_en_q    <= 5'h00;
      ir_nmi_q   <= 1'b0;
      ir_hit_q   <= 1'b0;
      ir_act_q   <= `SCT_ACT_RESET;
      ir_mask_q  <= 32'h0000_0000;
      ir_armed_q <= 1'b0;
    end
    else
    begin
      ir_hit_q <= ir_hit_d;
      if (wr_ir)
      begin
        ir_en_q  <= ir_en_w;
        ir_nmi_q <= wm[`SCT_IR_NMI];
        ir_act_q <= wm[`SCT_ACT_HI:`SCT_ACT_LO];
      end
      if (wr_mask)
        ir_mask_q <= wm & IRQ_IMPL;
      // armed from the trap until the handler's first instruction
      ir_armed_q <= (ir_armed_q || ir_match) && !handler_entry;
    end
  end

  // ----------------------------------------------------------------
  // firing outputs
  // ----------------------------------------------------------------

  wire [5:0] fire_act = ir_fire ? ir_act_q : st_act_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fire_q           <= 1'b0;
      fire_irq_q       <= 1'b0;
      fire_action_q    <= `SCT_ACT_RESET;
      fire_tval_zero_q <= 1'b0;
    end
    else
    begin
      fire_q           <= ir_fire || st_fire;
      fire_irq_q       <= ir_fire;
      fire_action_q    <= fire_act;
      fire_tval_zero_q <= (ir_fire || st_fire) && fire_act == 6'h00;
    end
  end

endmodule : sct_top

/* test/sct_hart_model.sv */
/*
  hart model: one-cycle retirement, trap and execution strobes.
  assumes each call starts right after a rising edge of aclk.
*/
`timescale 1ns/100ps

module sct_hart_model
  import sct_pkg::*;
(
  // clock
  input  wire logic  aclk,
  // retirement and traps
  output logic       retire_valid,
  output sct_mode_type retire_mode,
  output logic       retire_cfg_write,
  output logic       trap_valid,
  output sct_mode_type trap_from_mode,
  output logic       trap_is_irq,
  output logic       trap_is_nmi,
  output logic [4:0] trap_irq_code,
  // execution points
  output logic       exec_valid,
  output sct_mode_type exec_mode,
  output logic       handler_entry
);
  task automatic put(input logic [3:0] k, input sct_mode_type m, input logic [7:0] c);
    {retire_valid, trap_valid, exec_valid, handler_entry} <= k;
    retire_mode <= m;
    trap_from_mode <= m;
    exec_mode <= m;
    {retire_cfg_write, trap_is_irq, trap_is_nmi, trap_irq_code} <= c;
  endtask : put

  // qualifiers are scrambled when idle so stale values never pass
  task automatic st(input logic [3:0] k, input sct_mode_type m, input logic [7:0] c);
    put(k, m, c);
    @(posedge aclk);
    put(4'h0, sct_mode_type'(~m), ~c);
  endtask : st

  initial put(4'h0, SCT_MODE_U, 8'h00);
endmodule : sct_hart_model

/* test/sct_top_sva.sv */
/*
  checker of the step-count and interrupt trigger top ports.
  assumes it is bound to sct_top and sees only its ports.
*/
`timescale 1ns/100ps

module sct_top_sva
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // hart points and firing
  input wire logic        exec_valid,
  input wire logic        handler_entry,
  input wire logic        fire_q,
  input wire logic        fire_irq_q,
  input wire logic [5:0]  fire_action_q,
  input wire logic        fire_tval_zero_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  step_fire_exec_a: assert property (
    fire_q && !fire_irq_q |-> $past(exec_valid)) else $error("step fire without exec");
  irq_fire_entry_a: assert property (
    fire_q && fire_irq_q |-> $past(handler_entry)) else $error("irq fire without entry");
  tval_zero_only_a: assert property (
    fire_tval_zero_q |-> fire_q && fire_action_q == 6'h00) else $error("stray tval zero");
  tval_zero_need_a: assert property (
    fire_q && fire_action_q == 6'h00 |-> fire_tval_zero_q) else $error("tval zero missing");
  idle_no_fire_a: assert property (
    !exec_valid && !handler_entry |=> !fire_q) else $error("fire with no execution point");
  read_answer_a: assert property (
    arvalid && arready |=> rvalid) else $error("read answer late");
  read_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  write_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");

  cover property (fire_q && !fire_irq_q);
  cover property (fire_q && fire_irq_q);
  cover property (rvalid && rresp == 2'h2);
endmodule : sct_top_sva

/* test/step_count_irq_trigger_bench.sv */
/*
  bench of the step-count and interrupt trigger over axi4-lite and the hart model.
  assumes sct_top, sct_hart_model and sct_top_sva are compiled first.
*/
`timescale 1ns/100ps
`include "sct_cfg.svh"

module step_count_irq_trigger_bench;
  import sct_pkg::*;
  logic         aclk = 1'h0;
  logic         aresetn = 1'h0;
  logic [15:0]  awaddr = 16'h0, araddr = 16'h0;
  logic [31:0]  wdata = 32'h0, rdata;
  logic [3:0]   wstrb = 4'hf;
  logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic         awready, wready, bvalid, arready, rvalid, retire_valid, retire_cfg_write;
  logic         trap_valid, trap_is_irq, trap_is_nmi, exec_valid, handler_entry;
  logic         fire_q, fire_irq_q, fire_tval_zero_q;
  logic [1:0]   bresp, rresp;
  logic [4:0]   trap_irq_code;
  logic [5:0]   fire_action_q;
  sct_mode_type retire_mode, trap_from_mode, exec_mode;
  int           error_cnt = 0;
  int           checks = 0;

  always #5 aclk = ~aclk;

  sct_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .retire_valid, .retire_mode, .retire_cfg_write, .trap_valid, .trap_from_mode, .trap_is_irq,
    .trap_is_nmi, .trap_irq_code, .exec_valid, .exec_mode, .handler_entry, .fire_q,
    .fire_irq_q, .fire_action_q, .fire_tval_zero_q);

  sct_hart_model hart (.aclk, .retire_valid, .retire_mode, .retire_cfg_write, .trap_valid,
    .trap_from_mode, .trap_is_irq, .trap_is_nmi, .trap_irq_code, .exec_valid, .exec_mode,
    .handler_entry);

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    chk("bvalid", 32'(bvalid), 32'h1);
    chk("bresp", 32'(bresp), 32'(e));
  endtask : wr

  task automatic rd(input logic [11:0] i, input logic [31:0] x, input logic [1:0] e);
    int n;
    n = 0;
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    chk("rvalid", 32'(rvalid), 32'h1);
    chk("rdata", rdata, x);
    chk("rresp", 32'(rresp), 32'(e));
  endtask : rd

  // one hart event, then the fire outputs as {fire, irq, action, tval zero}
  task automatic ev(input logic [3:0] k, input sct_mode_type m, input logic [7:0] c,
                    input logic [8:0] e);
    hart.st(k, m, c);
    #1;
    chk("fire", {23'h0, fire_q, fire_irq_q, fire_action_q, fire_tval_zero_q}, {23'h0, e});
    // back onto a rising edge so the next request is launched there
    @(posedge aclk);
  endtask : ev

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`SCT_IDX_CONFIG, 32'h3000_0400, 2'h0);
    rd(12'h7a3, 32'h0, 2'h2);
    wr(12'h7a3, 32'hffff_ffff, 2'h2);
    wr(`SCT_IDX_CONFIG, 32'h0600_0ac0, 2'h0);
    rd(`SCT_IDX_CONFIG, 32'h3000_0ac0, 2'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_step;
    wr(`SCT_IDX_CONFIG, 32'h0000_0e00, 2'h0);
    ev(4'hc, SCT_MODE_M, 8'h00, 9'h000);
    rd(`SCT_IDX_CONFIG, 32'h3000_0a00, 2'h0);
    ev(4'h4, SCT_MODE_M, 8'h43, 9'h000);
    rd(`SCT_IDX_CONFIG, 32'h3000_0600, 2'h0);
    ev(4'h8, SCT_MODE_S, 8'h00, 9'h000);
    ev(4'h8, SCT_MODE_M, 8'h00, 9'h000);
    rd(`SCT_IDX_CONFIG, 32'h3000_0300, 2'h0);
    ev(4'h8, SCT_MODE_M, 8'h00, 9'h000);
    rd(`SCT_IDX_CONFIG, 32'h3000_0300, 2'h0);
    ev(4'h2, SCT_MODE_U, 8'h00, 9'h000);
    ev(4'h2, SCT_MODE_M, 8'h00, 9'h101);
    rd(`SCT_IDX_CONFIG, 32'h3100_0200, 2'h0);
    wr(`SCT_IDX_CONFIG, 32'h0000_0600, 2'h0);
    ev(4'h8, SCT_MODE_M, 8'h80, 9'h000);
    rd(`SCT_IDX_CONFIG, 32'h3000_0600, 2'h0);
    $display("test step done");
  endtask : t_step

  task automatic t_irq;
    wr(`SCT_IDX_SELECT, 32'h0000_0001, 2'h0);
    rd(`SCT_IDX_CONFIG, 32'h4000_0000, 2'h0);
    wr(`SCT_IDX_CONFIG, 32'h0000_0200, 2'h0);
    wr(`SCT_IDX_MATCH, 32'h8000_0008, 2'h0);
    rd(`SCT_IDX_MATCH, 32'h8000_0008, 2'h0);
    ev(4'h5, SCT_MODE_M, 8'h43, 9'h181);
    rd(`SCT_IDX_CONFIG, 32'h4400_0200, 2'h0);
    ev(4'h5, SCT_MODE_M, 8'h45, 9'h000);
    ev(4'h5, SCT_MODE_U, 8'h43, 9'h000);
    ev(4'h5, SCT_MODE_M, 8'h60, 9'h000);
    wr(`SCT_IDX_CONFIG, 32'h0000_0601, 2'h0);
    ev(4'h5, SCT_MODE_M, 8'h60, 9'h182);
    ev(4'h5, SCT_MODE_M, 8'h5f, 9'h182);
    ev(4'h4, SCT_MODE_M, 8'h43, 9'h000);
    rd(`SCT_IDX_STATUS, 32'h0000_000f, 2'h0);
    ev(4'h3, SCT_MODE_M, 8'h00, 9'h182);
    ev(4'h2, SCT_MODE_M, 8'h00, 9'h101);
    $display("test irq done");
  endtask : t_irq

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_step;
    t_irq;
    summarize;
  end

  // a run past 5000 cycles ends here; each handshake gives up after 50
  initial
  begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    summarize;
  end
endmodule : step_count_irq_trigger_bench

bind sct_top sct_top_sva u_sva (.aclk, .aresetn, .arvalid, .arready, .rvalid, .rready,
  .rdata, .rresp, .bvalid, .bready, .bresp, .exec_valid, .handler_entry, .fire_q,
  .fire_irq_q, .fire_action_q, .fire_tval_zero_q);
